// ### verilog/uwb_pkg.sv
// What this block does
// - with uart clock off and wake enabled, rx falling edge raises wake
// - no rx wake-up while the uart clock is running
// - enabled wake request gives interrupt; software turns clock back on
// - wake enable at 0 means rx edges never wake or request
// - receive enable 1: overrun or data-available set sets the uart flag
// - receive enable 0: overrun and data-available leave the flag alone
// - idle enable 1: transmitter idle set sets the uart flag
// - idle enable 0: transmitter idle leaves the flag alone
// - empty enable 1: transmitter empty set sets the uart flag
// - empty enable 0: transmitter empty leaves the flag alone
// - one 8-bit data location: writes transmit, reads receive
// - bit rate is clock over 64(N+1), or 16(N+1) in high speed
// - 8-bit read/write divisor N set by software before use
package uwb_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int BYTE_W = 8;
    localparam int CNT_W = 15;
    localparam int EVT_N = 4;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_DATA = 8'h04;
    localparam logic [7:0] OFF_BAUD = 8'h08;
    localparam logic [7:0] OFF_STAT = 8'h0C;
    localparam logic [7:0] OFF_MASK = 8'h10;
    localparam logic [7:0] OFF_LIVE = 8'h14;

    // uart_control_second fields
    localparam int CTL_TX_EMPTY_IRQ_ENABLE = 0;
    localparam int CTL_TIIE = 1;
    localparam int CTL_RIE = 2;
    localparam int CTL_WAKE = 3;
    localparam int CTL_HS = 5;
    localparam int CTL_CLKON = 7;

    // irq status / mask fields
    localparam int EV_RX = 0;
    localparam int EV_TRANSMITTER_QUIET_FLAG = 1;
    localparam int EV_TEMPTY = 2;
    localparam int EV_WAKE = 3;

    // live flag readback fields
    localparam int LV_OVR = 0;
    localparam int LV_RXAV = 1;
    localparam int LV_QUIET = 2;
    localparam int LV_EMPTY = 3;
    localparam int LV_RXPIN = 4;

    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [3:0] EVT_RST = 4'h0;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    localparam logic [14:0] BAUD_MUL_LOW = 15'h0040;
    localparam logic [14:0] BAUD_MUL_HIGH = 15'h0010;
    localparam logic [14:0] CNT_ZERO = 15'h0000;
    localparam logic [14:0] CNT_ONE = 15'h0001;
    localparam logic [8:0] DIV_ONE = 9'h001;
endpackage

// ### verilog/uwb_baud_gen.sv
`timescale 1ns/1ps
module uwb_baud_gen import uwb_pkg::*; (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic high_speed_i,
    input wire logic [7:0] divisor_i,
    output logic tick_o
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic tick;
    } uwb_baud_st_t;

    uwb_baud_st_t st;
    uwb_baud_st_t next_st;
    logic [8:0] n_plus;
    logic [CNT_W-1:0] period;

    always_comb begin
        next_st = st;
        n_plus = {1'b0, divisor_i} + DIV_ONE;
        period = CNT_W'(n_plus) * (high_speed_i ? BAUD_MUL_HIGH : BAUD_MUL_LOW);
        next_st.tick = 1'b0;
        if (!run_i) begin
            // gated uart clock: hold the divider at its start
            next_st.cnt = CNT_ZERO;
        end else if (st.cnt >= period - CNT_ONE) begin
            // >= so a smaller divisor written mid count wraps at once
            next_st.cnt = CNT_ZERO;
            next_st.tick = 1'b1;
        end else begin
            next_st.cnt = st.cnt + CNT_ONE;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick_o = st.tick;
endmodule

// ### verilog/uwb_ctrl.sv
`timescale 1ns/1ps
module uwb_ctrl import uwb_pkg::*; (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [DATA_W-1:0] reg_rdata_o,
    input wire logic rx_pin_i,
    input wire logic receive_overrun_flag_i,
    input wire logic receive_data_avail_flag_i,
    input wire logic transmitter_quiet_flag_i,
    input wire logic transmit_buffer_empty_flag_i,
    input wire logic [BYTE_W-1:0] rx_data_i,
    output logic [BYTE_W-1:0] tx_data_o,
    output logic tx_load_o,
    output logic rx_read_o,
    output logic uart_clk_en_o,
    output logic baud_high_speed_select_o,
    output logic [BYTE_W-1:0] baud_divisor_value_o,
    output logic baud_tick_o,
    output logic wake_req_o,
    output logic uart_irq_flag_o,
    output logic irq_o
);
    typedef struct packed {
        logic wake_en;
        logic receive_irq_enable;
        logic tx_idle_irq_enable;
        logic tx_empty_irq_enable;
        logic baud_high_speed_select;
        logic uart_clk_on;
        logic [BYTE_W-1:0] baud_divisor_value;
        logic [BYTE_W-1:0] serial_data_buffer;
        logic tx_load;
        logic rx_read;
        logic [EVT_N-1:0] status;
        logic [EVT_N-1:0] mask;
        logic [EVT_N-1:0] prev_flags;
        logic rx_meta;
        logic rx_sync;
        logic rx_prev;
        logic wake_req;
        logic irq;
        logic [DATA_W-1:0] rd_data;
    } uwb_ctrl_st_t;

    uwb_ctrl_st_t st;
    uwb_ctrl_st_t next_st;

    logic [EVT_N-1:0] flags_now;
    logic [EVT_N-1:0] flag_rise;
    logic [EVT_N-1:0] ev_set;
    logic [EVT_N-1:0] ev_clr;
    logic rx_fall;
    logic wake_fire;
    logic wr_ctrl;
    logic wr_data;
    logic wr_baud;
    logic wr_stat;
    logic wr_mask;
    logic rd_data_hit;
    logic [DATA_W-1:0] rd_word;

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0] off);
        hit = (a == off);
    endfunction

    function automatic logic rise(input logic prev, input logic cur);
        rise = cur & ~prev;
    endfunction

    function automatic logic [DATA_W-1:0] pad_byte(
            input logic [BYTE_W-1:0] b);
        pad_byte = {{(DATA_W-BYTE_W){1'b0}}, b};
    endfunction

    uwb_baud_gen u_baud (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .run_i(st.uart_clk_on),
        .high_speed_i(st.baud_high_speed_select),
        .divisor_i(st.baud_divisor_value),
        .tick_o(baud_tick_o)
    );

    always_comb begin
        next_st = st;
        flags_now = '0;
        flag_rise = '0;
        ev_set = '0;
        ev_clr = '0;
        rd_word = WORD_ZERO;

        // bus decode
        wr_ctrl = reg_write_i & hit(reg_addr_i, OFF_CTRL);
        wr_data = reg_write_i & hit(reg_addr_i, OFF_DATA);
        wr_baud = reg_write_i & hit(reg_addr_i, OFF_BAUD);
        wr_stat = reg_write_i & hit(reg_addr_i, OFF_STAT);
        wr_mask = reg_write_i & hit(reg_addr_i, OFF_MASK);
        rd_data_hit = reg_read_i & hit(reg_addr_i, OFF_DATA);

        // rx pin: two flops before any logic looks at it
        next_st.rx_meta = rx_pin_i;
        next_st.rx_sync = st.rx_meta;
        next_st.rx_prev = st.rx_sync;
        rx_fall = st.rx_prev & ~st.rx_sync;

        // edge counts only while the uart clock is gated and wake is set
        wake_fire = rx_fall & st.wake_en & ~st.uart_clk_on;

        // shifter flags arrive on this clock, no sync needed
        flags_now[EV_RX] = receive_overrun_flag_i;
        flags_now[EV_TRANSMITTER_QUIET_FLAG] = transmitter_quiet_flag_i;
        flags_now[EV_TEMPTY] = transmit_buffer_empty_flag_i;
        flags_now[EV_WAKE] = receive_data_avail_flag_i;
        for (int i = 0; i < EVT_N; i++) begin
            flag_rise[i] = rise(st.prev_flags[i], flags_now[i]);
        end
        next_st.prev_flags = flags_now;

        // slot EV_WAKE of prev_flags tracks data-available, it feeds EV_RX
        ev_set[EV_RX] = st.receive_irq_enable &
                        (flag_rise[EV_RX] | flag_rise[EV_WAKE]);
        ev_set[EV_TRANSMITTER_QUIET_FLAG] = st.tx_idle_irq_enable &
                           flag_rise[EV_TRANSMITTER_QUIET_FLAG];
        ev_set[EV_TEMPTY] = st.tx_empty_irq_enable &
                            flag_rise[EV_TEMPTY];
        ev_set[EV_WAKE] = wake_fire;

        // write-one-to-clear; a set in the same cycle wins
        if (wr_stat) begin
            ev_clr = reg_wdata_i[EVT_N-1:0];
        end
        next_st.status = (st.status & ~ev_clr) | ev_set;

        // wake request level stays until software restarts the clock
        if (wake_fire) begin
            next_st.wake_req = 1'b1;
        end else if (st.uart_clk_on) begin
            next_st.wake_req = 1'b0;
        end

        if (wr_ctrl) begin
            next_st.tx_empty_irq_enable = reg_wdata_i[CTL_TX_EMPTY_IRQ_ENABLE];
            next_st.tx_idle_irq_enable = reg_wdata_i[CTL_TIIE];
            next_st.receive_irq_enable = reg_wdata_i[CTL_RIE];
            next_st.wake_en = reg_wdata_i[CTL_WAKE];
            next_st.baud_high_speed_select = reg_wdata_i[CTL_HS];
            next_st.uart_clk_on = reg_wdata_i[CTL_CLKON];
        end

        if (wr_baud) begin
            next_st.baud_divisor_value = reg_wdata_i[BYTE_W-1:0];
        end

        if (wr_mask) begin
            next_st.mask = reg_wdata_i[EVT_N-1:0];
        end

        // one location: writes hand a byte to the transmitter
        next_st.tx_load = wr_data;
        if (wr_data) begin
            next_st.serial_data_buffer = reg_wdata_i[BYTE_W-1:0];
        end
        // reads hand the receiver's byte back and tell it it was taken
        next_st.rx_read = rd_data_hit;

        // read mux, answered in the next cycle only
        if (reg_read_i) begin
            case (reg_addr_i)
                OFF_CTRL: begin
                    rd_word[CTL_TX_EMPTY_IRQ_ENABLE] = st.tx_empty_irq_enable;
                    rd_word[CTL_TIIE] = st.tx_idle_irq_enable;
                    rd_word[CTL_RIE] = st.receive_irq_enable;
                    rd_word[CTL_WAKE] = st.wake_en;
                    rd_word[CTL_HS] = st.baud_high_speed_select;
                    rd_word[CTL_CLKON] = st.uart_clk_on;
                end
                OFF_DATA: begin
                    rd_word = pad_byte(rx_data_i);
                end
                OFF_BAUD: begin
                    rd_word = pad_byte(st.baud_divisor_value);
                end
                OFF_STAT: begin
                    rd_word[EVT_N-1:0] = st.status;
                end
                OFF_MASK: begin
                    rd_word[EVT_N-1:0] = st.mask;
                end
                OFF_LIVE: begin
                    rd_word[LV_OVR] = receive_overrun_flag_i;
                    rd_word[LV_RXAV] = receive_data_avail_flag_i;
                    rd_word[LV_QUIET] = transmitter_quiet_flag_i;
                    rd_word[LV_EMPTY] = transmit_buffer_empty_flag_i;
                    rd_word[LV_RXPIN] = st.rx_sync;
                end
                default: begin
                    rd_word = WORD_ZERO;
                end
            endcase
        end
        next_st.rd_data = rd_word;

        // irq follows the status that is about to be stored
        next_st.irq = |(next_st.status & next_st.mask);
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st.wake_en <= CTRL_RST[CTL_WAKE];
            st.receive_irq_enable <= CTRL_RST[CTL_RIE];
            st.tx_idle_irq_enable <= CTRL_RST[CTL_TIIE];
            st.tx_empty_irq_enable <= CTRL_RST[CTL_TX_EMPTY_IRQ_ENABLE];
            st.baud_high_speed_select <= CTRL_RST[CTL_HS];
            st.uart_clk_on <= CTRL_RST[CTL_CLKON];
            st.baud_divisor_value <= BYTE_RST;
            st.serial_data_buffer <= BYTE_RST;
            st.tx_load <= 1'b0;
            st.rx_read <= 1'b0;
            st.status <= EVT_RST;
            st.mask <= EVT_RST;
            st.prev_flags <= EVT_RST;
            // idle line is high; avoids a false edge at reset release
            st.rx_meta <= 1'b1;
            st.rx_sync <= 1'b1;
            st.rx_prev <= 1'b1;
            st.wake_req <= 1'b0;
            st.irq <= 1'b0;
            st.rd_data <= WORD_ZERO;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata_o = st.rd_data;
    assign tx_data_o = st.serial_data_buffer;
    assign tx_load_o = st.tx_load;
    assign rx_read_o = st.rx_read;
    assign uart_clk_en_o = st.uart_clk_on;
    assign baud_high_speed_select_o = st.baud_high_speed_select;
    assign baud_divisor_value_o = st.baud_divisor_value;
    assign wake_req_o = st.wake_req;
    assign uart_irq_flag_o = |st.status;
    assign irq_o = st.irq;
endmodule

// ### testbench/uwb_ctrl_assertions.sv
`timescale 1ns/1ps
module uwb_ctrl_chk import uwb_pkg::*; (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    input wire logic [DATA_W-1:0] reg_rdata_o,
    input wire logic [BYTE_W-1:0] rx_data_i,
    input wire logic [BYTE_W-1:0] tx_data_o,
    input wire logic tx_load_o,
    input wire logic rx_read_o,
    input wire logic uart_clk_en_o,
    input wire logic baud_high_speed_select_o,
    input wire logic [BYTE_W-1:0] baud_divisor_value_o,
    input wire logic baud_tick_o,
    input wire logic wake_req_o,
    input wire logic uart_irq_flag_o,
    input wire logic irq_o
);
    logic [15:0] cnt;
    logic seen;
    logic [15:0] per;
    // period only judged between two ticks of one run
    assign per = (baud_high_speed_select_o ? 16'h0010 : 16'h0040) *
        ({8'h00, baud_divisor_value_o} + 16'h0001);
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || !uart_clk_en_o) begin
            cnt <= 16'h0000;
            seen <= 1'b0;
        end else if (baud_tick_o) begin
            cnt <= 16'h0001;
            seen <= 1'b1;
        end else begin
            cnt <= cnt + 16'h0001;
        end
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    wake_gate_a: assert property (
        $rose(wake_req_o) |-> !$past(uart_clk_en_o))
        else $error("wake request raised with uart clock on");
    wake_drop_a: assert property (
        uart_clk_en_o [*2] |-> !wake_req_o)
        else $error("wake request kept with uart clock on");
    irq_src_a: assert property (
        irq_o |-> uart_irq_flag_o)
        else $error("interrupt without request flag");
    tx_load_a: assert property (
        reg_write_i && reg_addr_i == OFF_DATA |=> tx_load_o &&
        tx_data_o == $past(reg_wdata_i[BYTE_W-1:0]))
        else $error("data write not passed on");
    rx_read_a: assert property (
        reg_read_i && reg_addr_i == OFF_DATA |=> rx_read_o &&
        reg_rdata_o == {24'h00_0000, $past(rx_data_i)})
        else $error("data read wrong");
    rd_idle_a: assert property (
        !reg_read_i |=> reg_rdata_o == WORD_ZERO)
        else $error("read data outside read cycle");
    baud_wr_a: assert property (
        reg_write_i && reg_addr_i == OFF_BAUD |=>
        baud_divisor_value_o == $past(reg_wdata_i[BYTE_W-1:0]))
        else $error("divisor write lost");
    tick_gate_a: assert property (
        baud_tick_o |-> uart_clk_en_o)
        else $error("tick with uart clock off");
    tick_period_a: assert property (
        baud_tick_o && seen |-> cnt == per)
        else $error("bit period wrong");
endmodule
bind uwb_ctrl uwb_ctrl_chk i_chk(.*);

// ### testbench/uwb_remote_node.sv
`timescale 1ns/1ps
module uwb_remote_node (
    input wire logic clk_sys_i,
    output logic rx_pin_o,
    output logic [3:0] flags_o,
    output logic [7:0] byte_o
);
    initial begin
        rx_pin_o = 1'b1;
        flags_o = 4'h0;
        byte_o = 8'h00;
    end
    // start bit low, then back to idle mark
    task automatic pull_rx(input int n);
        @(posedge clk_sys_i);
        rx_pin_o <= 1'b0;
        repeat (n) @(posedge clk_sys_i);
        rx_pin_o <= 1'b1;
    endtask
    // flags[0] overrun, [1] data, [2] quiet, [3] empty
    task automatic raise(input int b, input logic [7:0] d);
        @(posedge clk_sys_i);
        byte_o <= d;
        flags_o[b] <= 1'b1;
        @(posedge clk_sys_i);
        flags_o[b] <= 1'b0;
    endtask
endmodule

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench import uwb_pkg::*;;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [7:0] tx_data, rx_byte;
    logic tx_load, tick, wake, irq, rx_pin;
    logic uflag, rx_read, clk_en;
    logic [3:0] flags;
    int failures = 0;
    int comparisons = 0;
    always #2.5 clk_sys_i = ~clk_sys_i;
    uwb_remote_node i_uwb_remote_node (.clk_sys_i(clk_sys_i),
        .rx_pin_o(rx_pin), .flags_o(flags), .byte_o(rx_byte));
    uwb_ctrl i_uwb_ctrl (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_write_i(wr),
        .reg_read_i(rd), .reg_rdata_o(rdata), .rx_pin_i(rx_pin),
        .receive_overrun_flag_i(flags[0]),
        .receive_data_avail_flag_i(flags[1]),
        .transmitter_quiet_flag_i(flags[2]),
        .transmit_buffer_empty_flag_i(flags[3]), .rx_data_i(rx_byte),
        .tx_data_o(tx_data), .tx_load_o(tx_load), .rx_read_o(rx_read),
        .uart_clk_en_o(clk_en), .baud_high_speed_select_o(),
        .baud_divisor_value_o(), .baud_tick_o(tick), .wake_req_o(wake),
        .uart_irq_flag_o(uflag), .irq_o(irq));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys_i);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task automatic t_regs;
        rd_chk(OFF_CTRL, WORD_ZERO);
        wr_reg(OFF_BAUD, 32'h0000_00FF);
        rd_chk(OFF_BAUD, 32'h0000_00FF);
        wr_reg(8'h18, 32'hFFFF_FFFF);
        rd_chk(8'h18, WORD_ZERO);
        wr_reg(OFF_DATA, 32'h0000_005A);
        chk({23'h0, tx_load, tx_data}, 32'h0000_015A);
        i_uwb_remote_node.raise(1, 8'hC3);
        rd_chk(OFF_DATA, 32'h0000_00C3);
        chk(rx_read, 1'b1);
        $display("test regs done");
    endtask
    task automatic t_events;
        int ev[4] = '{0, 0, 1, 2};
        int en[4] = '{2, 2, 1, 0};
        for (int i = 0; i < 4; i++) begin
            wr_reg(OFF_CTRL, 32'h0000_0000);
            i_uwb_remote_node.raise(i, 8'h11);
            rd_chk(OFF_STAT, WORD_ZERO);
            wr_reg(OFF_MASK, 32'h0000_0000);
            wr_reg(OFF_CTRL, 1 << en[i]);
            i_uwb_remote_node.raise(i, 8'h22);
            #1 chk({uflag, irq}, 2'b10);
            wr_reg(OFF_MASK, 32'h0000_000F);
            rd_chk(OFF_STAT, 1 << ev[i]);
            chk(irq, 1'b1);
            wr_reg(OFF_STAT, 1 << ev[i]);
            rd_chk(OFF_STAT, WORD_ZERO);
            chk(irq, 1'b0);
        end
        $display("test events done");
    endtask
    task automatic t_wake;
        wr_reg(OFF_MASK, 32'h0000_0008);
        wr_reg(OFF_CTRL, 32'h0000_0008);
        i_uwb_remote_node.pull_rx(3);
        repeat (6) @(posedge clk_sys_i);
        #1 chk({wake, irq}, 2'b11);
        wr_reg(OFF_CTRL, 32'h0000_0088);
        chk({clk_en, wake}, 2'b11);
        @(posedge clk_sys_i);
        #1 chk(wake, 1'b0);
        wr_reg(OFF_STAT, 32'h0000_0008);
        i_uwb_remote_node.pull_rx(3);
        repeat (6) @(posedge clk_sys_i);
        rd_chk(OFF_STAT, WORD_ZERO);
        wr_reg(OFF_CTRL, 32'h0000_0000);
        i_uwb_remote_node.pull_rx(3);
        repeat (6) @(posedge clk_sys_i);
        #1 chk(wake, 1'b0);
        rd_chk(OFF_STAT, WORD_ZERO);
        $display("test wake done");
    endtask
    task automatic wait_tick(output int n);
        n = 0;
        do begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end while (tick !== 1'b1 && n < 2000);
    endtask
    task automatic t_baud;
        int n;
        for (int hs = 0; hs < 2; hs++) begin
            wr_reg(OFF_BAUD, 32'h0000_0002);
            wr_reg(OFF_CTRL, 32'h0000_0080 | (hs << 5));
            wait_tick(n);
            wait_tick(n);
            chk(n, (hs == 1 ? 16 : 64) * 3);
            wr_reg(OFF_CTRL, 32'h0000_0000);
        end
        $display("test baud done");
    endtask
    // reset again mid-run, with state that differs from the reset values
    task automatic t_reset;
        wr_reg(OFF_BAUD, 32'h0000_0033);
        wr_reg(OFF_DATA, 32'h0000_00A5);
        wr_reg(OFF_CTRL, 32'h0000_00AF);
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        #1 chk({tx_data, clk_en, tick, wake, irq}, 12'h000);
        rd_chk(OFF_BAUD, WORD_ZERO);
        rd_chk(OFF_CTRL, WORD_ZERO);
        $display("test reset done");
    endtask
    task automatic test_done;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        test_done;
    end
    initial begin
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        t_regs;
        t_events;
        t_wake;
        t_baud;
        t_reset;
        test_done;
    end
endmodule
